/* File: src/pwmdo_pkg.sv */
// constants for the 14-bit pwm duty data and output drive block
package pwmdo_pkg;
    localparam int CHANNELS = 3;
    localparam int ADDR_W   = 10;
    localparam int DATA_W   = 32;
    localparam int LO_W     = 8;
    localparam int HI_W     = 6;
    localparam int POS_W    = 8;
    localparam int SUBS_W   = 6;
    localparam int FRAME_W  = POS_W + SUBS_W;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_DRIVE  = 8'h21;
    localparam logic [7:0] IDX_START  = 8'h3d;
    localparam logic [7:0] IDX_STATUS = 8'h44;
    localparam logic [2:0][7:0] IDX_LO = {8'h42, 8'h40, 8'h3e};
    localparam logic [2:0][7:0] IDX_HI = {8'h43, 8'h41, 8'h3f};
    // drive bit positions: channel 0, channel 1, channel 2 shared with port line a3
    localparam logic [2:0][2:0] DRV_POS = {3'h0, 3'h4, 3'h3};
    localparam logic [2:0] DRIVE_RST   = 3'h0;
    localparam logic [2:0] RUN_RST     = 3'h0;
    localparam int STATUS_PEND_POS     = 3;
    localparam int FRAME_CLOCKS        = 1 << FRAME_W;
    localparam int SUBPERIODS          = 1 << SUBS_W;
endpackage

/* File: src/pwmdo_chan.sv */
// one 14-bit pwm channel: comparison latches, frame counter and output level
`timescale 1ns/1ps
module pwmdo_chan
    import pwmdo_pkg::*;
#(
    parameter int LW = LO_W,
    parameter int HW = HI_W,
    parameter int PW = POS_W,
    parameter int SW = SUBS_W
) (
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    // control and data
    input  wire logic          run_in,
    input  wire logic [LW-1:0] lo_in,
    input  wire logic [HW-1:0] hi_in,
    input  wire logic          hi_wr_in,
    // state
    output logic               level_out,
    output logic               pending_out
);
    logic [PW+SW-1:0] cnt_ff;
    logic [LW-1:0]    m_ff;
    logic [HW-1:0]    n_ff;
    logic             pend_ff;
    logic             level_ff;
    logic [PW-1:0]    pos;
    logic [SW-1:0]    sub;
    logic [SW-1:0]    rev;
    logic             ts_start;
    logic             load;
    logic             extra;
    logic [PW:0]      width;

    assign pos      = cnt_ff[PW-1:0];
    assign sub      = cnt_ff[PW+SW-1:PW];
    assign ts_start = run_in && (pos == '0);
    // while stopped no sub-period starts, so a pending load goes straight in
    assign load     = pend_ff && (ts_start || !run_in);

    // bit-reversed sub-period index spreads the extra clocks over the frame
    for (genvar b = 0; b < SW; b++) begin : g_rev
        assign rev[b] = sub[SW-1-b];
    end
    assign extra = {{(LW-SW){1'b0}}, rev} < m_ff;                   // R11
    assign width = {{(PW+1-HW){1'b0}}, n_ff} + {{PW{1'b0}}, extra}; // R11

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_ff <= '0;
        end else if (!run_in) begin
            cnt_ff <= '0; // R13
        end else begin
            cnt_ff <= cnt_ff + 1'b1; // R11
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pend_ff <= 1'b0;
        end else if (hi_wr_in) begin
            pend_ff <= 1'b1; // R10
        end else if (load) begin
            pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            m_ff <= '0;
            n_ff <= '0;
        end else if (load) begin
            m_ff <= lo_in; // R10
            n_ff <= hi_in; // R10
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            level_ff <= 1'b0;
        end else begin
            level_ff <= run_in && ({1'b0, pos} < width); // R12
        end
    end

    assign level_out   = level_ff;
    assign pending_out = pend_ff;

    stop_low_a: assert property (@(posedge clk_in) disable iff (rst_in) // R12
        !run_in |=> !level_out)
        else $error("stopped channel output not low");
    restart_a: assert property (@(posedge clk_in) disable iff (rst_in) // R13
        $rose(run_in) |-> cnt_ff == '0)
        else $error("frame counter not zero at start");
    latch_ts_a: assert property (@(posedge clk_in) disable iff (rst_in) // R10
        pend_ff && ts_start && !hi_wr_in |=> !pend_ff && n_ff == $past(hi_in))
        else $error("latch not loaded at sub-period start");
    width_a: assert property (@(posedge clk_in) disable iff (rst_in) // R11
        run_in && ({1'b0, pos} > {{(PW+1-HW){1'b0}}, n_ff}) |=> !level_out)
        else $error("pulse longer than n plus one");
    frame_a: assert property (@(posedge clk_in) disable iff (rst_in) // R11
        run_in && (&cnt_ff) ##1 run_in |-> cnt_ff == '0)
        else $error("frame not 2^14 clocks");
    load_c: cover property (@(posedge clk_in) disable iff (rst_in)
        pend_ff && ts_start ##1 !pend_ff);
    frame_c: cover property (@(posedge clk_in) disable iff (rst_in)
        run_in && (&cnt_ff) ##1 level_out);
endmodule

/* File: src/pwmdo_top.sv */
// avalon register file for pwm duty data, start and output drive, three channels
// How it works
// R1 - index 40h holds channel 1 duty bits 7..0, write only.
// R2 - index 41h bits 5..0 hold channel 1 duty bits 13..8, write only.
// R3 - index 42h holds channel 2 duty bits 7..0, write only.
// R4 - index 43h bits 5..0 hold channel 2 duty bits 13..8, write only.
// R5 - software writes whole duty values, never read-modify-write.
// R6 - drive register bit 3 channel 0, bit 4 channel 1: 1 open-drain.
// R7 - drive register bit 0 selects port a3 / channel 2 pin drive.
// R8 - reset clears all three drive bits to push-pull.
// R9 - drive register is write only; software writes whole bytes.
// R10 - low half first; both halves latch at next sub-period after high write. While stopped, the code latches them on the next clock.
// R11 - frame of 2^14 clocks, 64 sub-periods, n high, m get one extra.
// R12 - channel outputs only while its start bit is one.
// R13 - stopped channel holds low and restarts frame from zero.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
module pwmdo_top
    import pwmdo_pkg::*;
#(
    parameter int NCH = CHANNELS
) (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [DATA_W-1:0] avs_writedata_in,
    input  wire logic [3:0]        avs_byteenable_in,
    output logic [DATA_W-1:0]      avs_readdata_out,
    output logic                   avs_waitrequest_out,
    // pwm pins
    output logic [NCH-1:0]         pwm_pin_out,
    output logic [NCH-1:0]         pwm_pin_oe_out
);
    logic                  ack_ff;
    logic [DATA_W-1:0]     rdata_ff;
    logic                  req;
    logic                  wr_go;
    logic                  rd_go;
    logic [7:0]            idx;
    logic                  aligned;
    logic                  lane0;
    logic [LO_W-1:0]       lo_ff [NCH];
    logic [HI_W-1:0]       hi_ff [NCH];
    logic [NCH-1:0]        run_ff;
    logic [NCH-1:0]        drv_ff;
    logic [NCH-1:0]        lo_wr;
    logic [NCH-1:0]        hi_wr;
    logic                  drv_wr;
    logic                  run_wr;
    logic [NCH-1:0]        level;
    logic [NCH-1:0]        pending;
    logic [NCH-1:0]        pin_ff;
    logic [NCH-1:0]        oe_ff;
    logic [DATA_W-1:0]     nxt_rdata;

    // one wait state: request seen in cycle 0, answered in cycle 1
    assign req                 = avs_read_in || avs_write_in;
    assign avs_waitrequest_out = req && !ack_ff;
    assign wr_go               = avs_write_in && ack_ff;
    assign rd_go               = avs_read_in && !ack_ff;
    assign idx                 = avs_address_in[ADDR_W-1:2];
    assign aligned             = avs_address_in[1:0] == 2'h0;
    assign lane0               = avs_byteenable_in[0];
    assign drv_wr = wr_go && lane0 && aligned && (idx == IDX_DRIVE);
    assign run_wr = wr_go && lane0 && aligned && (idx == IDX_START);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req && !ack_ff;
        end
    end

    // duty and drive registers read as zero; only start and status return state
    always_comb begin
        nxt_rdata = '0;
        if (aligned && idx == IDX_START) begin
            nxt_rdata[NCH-1:0] = run_ff;
        end else if (aligned && idx == IDX_STATUS) begin
            nxt_rdata[NCH-1:0] = level;
            nxt_rdata[STATUS_PEND_POS +: NCH] = pending;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_ff <= '0;
        end else if (rd_go) begin
            rdata_ff <= nxt_rdata; // R9
        end
    end
    assign avs_readdata_out = rdata_ff;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            drv_ff <= DRIVE_RST; // R8
        end else if (drv_wr) begin
            for (int i = 0; i < NCH; i++) begin
                drv_ff[i] <= avs_writedata_in[DRV_POS[i]]; // R6
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_ff <= RUN_RST;
        end else if (run_wr) begin
            run_ff <= avs_writedata_in[NCH-1:0]; // R12
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        assign lo_wr[c] = wr_go && lane0 && aligned && (idx == IDX_LO[c]);
        assign hi_wr[c] = wr_go && lane0 && aligned && (idx == IDX_HI[c]);

        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                lo_ff[c] <= '0;
            end else if (lo_wr[c]) begin
                lo_ff[c] <= avs_writedata_in[LO_W-1:0]; // R1 R3
            end
        end

        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                hi_ff[c] <= '0;
            end else if (hi_wr[c]) begin
                hi_ff[c] <= avs_writedata_in[HI_W-1:0]; // R2 R4
            end
        end

        pwmdo_chan #(
            .LW (LO_W),
            .HW (HI_W),
            .PW (POS_W),
            .SW (SUBS_W)
        ) u_chan (
            .clk_in      (clk_in),
            .rst_in      (rst_in),
            .run_in      (run_ff[c]),
            .lo_in       (lo_ff[c]),
            .hi_in       (hi_ff[c]),
            .hi_wr_in    (hi_wr[c]),
            .level_out   (level[c]),
            .pending_out (pending[c])
        );

        // open-drain pulls low for a low level and floats for a high one
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                pin_ff[c] <= 1'b0;
                oe_ff[c]  <= 1'b1;
            end else if (drv_ff[c]) begin
                pin_ff[c] <= 1'b0;      // R7
                oe_ff[c]  <= !level[c]; // R6
            end else begin
                pin_ff[c] <= level[c];
                oe_ff[c]  <= 1'b1;
            end
        end
    end

    assign pwm_pin_out    = pin_ff;
    assign pwm_pin_oe_out = oe_ff;

    wait_one_a: assert property (@(posedge clk_in) disable iff (rst_in)
        avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("waitrequest held more than one cycle");
    lo1_a: assert property (@(posedge clk_in) disable iff (rst_in) // R1
        lo_wr[1] |=> lo_ff[1] == $past(avs_writedata_in[LO_W-1:0]))
        else $error("channel 1 low duty not stored");
    hi1_a: assert property (@(posedge clk_in) disable iff (rst_in) // R2
        hi_wr[1] |=> hi_ff[1] == $past(avs_writedata_in[HI_W-1:0]) && pending[1])
        else $error("channel 1 high duty not stored or not pending");
    lo2_a: assert property (@(posedge clk_in) disable iff (rst_in) // R3
        wr_go && lane0 && aligned && idx == 8'h42
        |=> lo_ff[2] == $past(avs_writedata_in[LO_W-1:0]))
        else $error("channel 2 low duty not stored");
    hi2_a: assert property (@(posedge clk_in) disable iff (rst_in) // R4
        wr_go && lane0 && aligned && idx == 8'h43
        |=> hi_ff[2] == $past(avs_writedata_in[HI_W-1:0]))
        else $error("channel 2 high duty not stored");
    wo_read_a: assert property (@(posedge clk_in) disable iff (rst_in) // R9
        rd_go && aligned && (idx == IDX_DRIVE || idx == IDX_HI[1])
        |=> avs_readdata_out == '0 && !avs_waitrequest_out)
        else $error("write-only register returned data");
    od_pin_a: assert property (@(posedge clk_in) disable iff (rst_in) // R7
        drv_ff[2] |=> !pwm_pin_out[2])
        else $error("open-drain pin driven high");
    pp_pin_a: assert property (@(posedge clk_in) disable iff (rst_in) // R6
        !drv_ff[0] |=> pwm_pin_oe_out[0] && pwm_pin_out[0] == $past(level[0]))
        else $error("push-pull pin not following level");
    drv_rst_a: assert property (@(posedge clk_in) // R8
        rst_in |=> drv_ff == DRIVE_RST)
        else $error("drive bits not cleared by reset");
    od_c: cover property (@(posedge clk_in) disable iff (rst_in)
        drv_ff[1] && level[1] ##1 !pwm_pin_oe_out[1]);
    rd_c: cover property (@(posedge clk_in) disable iff (rst_in)
        rd_go && idx == IDX_STATUS ##1 avs_readdata_out != '0);
endmodule

/* File: sim/pwmdo_top_tb.sv */
// self-checking bench for the pwm duty data and output drive register block
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected at %0t got %h exp %h", $time, (got), (exp)); end end
module pwmdo_top_tb
    import pwmdo_pkg::*;
;
    logic                   clk_in;
    logic                   rst_in;
    logic [ADDR_W-1:0]      avs_address_in;
    logic                   avs_read_in;
    logic                   avs_write_in;
    logic [DATA_W-1:0]      avs_writedata_in;
    logic [3:0]             avs_byteenable_in;
    logic [DATA_W-1:0]      avs_readdata_out;
    logic                   avs_waitrequest_out;
    logic [CHANNELS-1:0]    pwm_pin_out;
    logic [CHANNELS-1:0]    pwm_pin_oe_out;
    int                     err_total;
    int                     n_tests;
    logic [2:0]             drv;
    logic [5:0]             n_v [3];
    logic [7:0]             m_v [3];
    logic [DATA_W-1:0]      rd;
    logic [7:0]             wo_idx [8];

    pwmdo_top #(.NCH(CHANNELS)) dut_u (
        .clk_in              (clk_in),
        .rst_in              (rst_in),
        .avs_address_in      (avs_address_in),
        .avs_read_in         (avs_read_in),
        .avs_write_in        (avs_write_in),
        .avs_writedata_in    (avs_writedata_in),
        .avs_byteenable_in   (avs_byteenable_in),
        .avs_readdata_out    (avs_readdata_out),
        .avs_waitrequest_out (avs_waitrequest_out),
        .pwm_pin_out         (pwm_pin_out),
        .pwm_pin_oe_out      (pwm_pin_oe_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // high clocks in one frame: n per sub-period plus one in min(m, 64) of the 64 sub-periods
    function automatic int exp_high(input logic [5:0] n, input logic [7:0] m);
        return SUBPERIODS * int'(n) + ((int'(m) > SUBPERIODS) ? SUBPERIODS : int'(m));
    endfunction

    function automatic logic [7:0] drv_byte(input logic [2:0] d);
        logic [7:0] b;
        b = 8'h00;
        for (int c = 0; c < CHANNELS; c++) b[DRV_POS[c]] = d[c];
        return b;
    endfunction

    // modulated level as seen on the pin under the selected drive mode
    function automatic logic lvl(input int c);
        return drv[c] ? ~pwm_pin_oe_out[c] : pwm_pin_out[c];
    endfunction

    // request holds until waitrequest is seen low at a rising edge; readdata taken there
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] val,
                       input logic [3:0] be);
        int k;
        k = 0;
        @(posedge clk_in);
        avs_address_in    <= {idx, 2'b00};
        avs_read_in       <= ~wr;
        avs_write_in      <= wr;
        avs_writedata_in  <= {24'($urandom), val};
        avs_byteenable_in <= be;
        do begin
            @(posedge clk_in);
            k++;
        end while (avs_waitrequest_out !== 1'b0 && k < 16);
        rd = avs_readdata_out;
        `CHK(avs_waitrequest_out, 1'b0)
        avs_read_in  <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    // upper bits of the high write are set to show they are ignored
    task automatic set_duty(input int c, input logic [7:0] m, input logic [5:0] n);
        bus(1'b1, IDX_LO[c], m, 4'hf);
        bus(1'b1, IDX_HI[c], {2'b11, n}, 4'h1);
    endtask

    task automatic measure(input string name);
        int cnt [3];
        int bad;
        cnt = '{0, 0, 0};
        bad = 0;
        for (int i = 0; i < FRAME_CLOCKS; i++) begin
            @(negedge clk_in);
            for (int c = 0; c < CHANNELS; c++) begin
                if (lvl(c) === 1'b1) cnt[c]++;
                if (drv[c] ? pwm_pin_out[c] !== 1'b0 : pwm_pin_oe_out[c] !== 1'b1) bad++;
            end
        end
        for (int c = 0; c < CHANNELS; c++) `CHK(cnt[c], exp_high(n_v[c], m_v[c]))
        `CHK(bad, 0)
        $display("test %s done", name);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk_in);
        err_total++;
        complete_run();
    end

    initial begin
        rst_in = 1'b1;
        avs_address_in = '0;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = '0;
        avs_byteenable_in = 4'h0;
        err_total = 0;
        n_tests = 0;
        drv = 3'h0;
        rd = '0;
        wo_idx = '{IDX_DRIVE, IDX_LO[0], IDX_LO[1], IDX_LO[2],
                   IDX_HI[0], IDX_HI[1], IDX_HI[2], 8'h3c};
        void'($urandom(32'h3adc201a));
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        @(negedge clk_in);
        `CHK(pwm_pin_out, 3'h0)
        `CHK(pwm_pin_oe_out, 3'h7)
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, wo_idx[i], 8'(($urandom % 256) | 1), 4'hf);
            bus(1'b0, wo_idx[i], 8'h00, 4'hf);
            `CHK(rd, 32'h0)
        end
        $display("test write only reads done");
        drv = 3'($urandom);
        bus(1'b1, IDX_DRIVE, drv_byte(drv) | 8'he6, 4'hf);
        n_v = '{6'h3f, 6'h00, 6'($urandom)};
        m_v = '{8'hff, 8'($urandom % 64), 8'($urandom)};
        for (int c = 0; c < CHANNELS; c++) set_duty(c, m_v[c], n_v[c]);
        bus(1'b1, IDX_START, 8'h07, 4'hf);
        // level registers one edge after the start bit lands, the pin one edge later
        repeat (1) @(posedge clk_in);
        @(negedge clk_in);
        `CHK(lvl(0), 1'b0)
        @(negedge clk_in);
        `CHK(lvl(0), 1'b1)
        bus(1'b1, IDX_START, 8'h00, 4'he);
        bus(1'b0, IDX_START, 8'h00, 4'hf);
        `CHK(rd[2:0], 3'h7)
        measure("frame after stopped load");
        drv = ~drv;
        bus(1'b1, IDX_DRIVE, drv_byte(drv), 4'hf);
        for (int c = 0; c < CHANNELS; c++) begin
            n_v[c] = 6'($urandom);
            m_v[c] = 8'($urandom);
            set_duty(c, m_v[c], n_v[c]);
        end
        repeat (300) @(posedge clk_in);
        measure("reload while running");
        for (int c = 0; c < CHANNELS; c++) bus(1'b1, IDX_LO[c], ~m_v[c], 4'hf);
        repeat (300) @(posedge clk_in);
        measure("low half alone holds");
        bus(1'b1, IDX_START, 8'h00, 4'hf);
        repeat (3) @(posedge clk_in);
        for (int i = 0; i < 64; i++) begin
            @(negedge clk_in);
            `CHK(pwm_pin_out & ~drv, 3'h0)
            `CHK(pwm_pin_oe_out | ~drv, 3'h7)
        end
        bus(1'b0, IDX_STATUS, 8'h00, 4'hf);
        `CHK(rd[5:0], 6'h00)
        $display("test stop done");
        complete_run();
    end
endmodule
